// ===== core/cmd_decode_pkg.sv
// package: command codes, decoded command carrier, timing counts
package cmd_decode_pkg;
   // first-edge opcode on ca[4:0] with cs high (ca0 is bit 0)
   localparam logic [4:0] OP_MPC   = 5'h00; // l,l,l,l,l
   localparam logic [4:0] OP_PRE   = 5'h10; // l,l,l,l,h
   localparam logic [4:0] OP_REF   = 5'h08; // l,l,l,h,l
   localparam logic [4:0] OP_SRE   = 5'h18; // l,l,l,h,h
   localparam logic [4:0] OP_WR1   = 5'h04; // l,l,h,l,l
   localparam logic [4:0] OP_SRX   = 5'h14; // l,l,h,l,h
   localparam logic [4:0] OP_MWR1  = 5'h0C; // l,l,h,h,l
   localparam logic [4:0] OP_RD1   = 5'h02; // l,h,l,l,l
   localparam logic [4:0] OP_CAS2  = 5'h12; // l,h,l,l,h
   localparam logic [4:0] OP_MRW1  = 5'h06; // l,h,h,l,l
   localparam logic [4:0] OP_MRW2  = 5'h16; // l,h,h,l,h
   localparam logic [4:0] OP_MRR1  = 5'h0E; // l,h,h,h,l
   // field positions
   localparam int CA_AB  = 5;   // all-bank / burst / op bit on ca5
   localparam int CA_ACT = 0;   // ca0 high marks activate
   localparam int CA_AC2 = 1;   // ca1 selects activate-2
   // burst lengths
   localparam logic [5:0] BL_LONG  = 6'h20;
   localparam logic [5:0] BL_SHORT = 6'h10;
   // ready delay after clock change: 2 tck plus txp
   localparam int TCK_PS     = 4000;
   localparam int TXP_PS     = 7500; // analog part of the exit delay
   localparam int TXP_NCK    = 5;
   localparam int TXP_CYC_PS = (TXP_PS + TCK_PS - 1) / TCK_PS;
   localparam int TXP_CYC    = (TXP_CYC_PS > TXP_NCK) ? TXP_CYC_PS : TXP_NCK;
   localparam int READY_CYC  = 2 + TXP_CYC;
   localparam logic [3:0] READY_CNT = 4'(READY_CYC);

   typedef enum logic [3:0] {
      CMD_NONE = 4'h0, CMD_MPC = 4'h1, CMD_PRE = 4'h2, CMD_REF = 4'h3,
      CMD_SRE  = 4'h4, CMD_SRX = 4'h5, CMD_WR1 = 4'h6, CMD_MWR1 = 4'h7,
      CMD_RD1  = 4'h8, CMD_CAS2 = 4'h9, CMD_MRW1 = 4'hA, CMD_MRW2 = 4'hB,
      CMD_MRR1 = 4'hC, CMD_ACT1 = 4'hD, CMD_ACT2 = 4'hE, CMD_RFU = 4'hF
   } cmd_t;

   typedef struct packed {
      cmd_t       cmd;      // decoded command
      logic       hi_bit;   // ca5 of first edge (ab, bl, op7, op6, c8)
      logic [5:0] first;    // first-edge ca
      logic [5:0] second;   // second-edge ca
      logic       all_bank; // precharge/refresh to every bank
      logic [2:0] bank;     // bank address
      logic [5:0] burst;    // burst length for read/write
   } cmd_word_t;
endpackage

// ===== core/cmd_decode.sv
// command-bus decoder with clock stop and frequency change gating
// Function
// - device ignores clock pins while stopped with cke low
// - device ready only 2 tck plus txp after cke-high clock change
// - cas-2 decoded from l,h,l,l,h,c8 then c2..c7
// - precharge and refresh decoded; bank from second-edge ca0..ca2
// - commands span two edges; deselect spans one
// - all-bank bit applies precharge or refresh to every bank
// - on-the-fly burst bit selects length 32 or 16
`timescale 1ns/1ns
module cmd_decode (
   input  wire logic                     clk_i,      // ck_t rising edge
   input  wire logic                     rstn_i,     // sync reset, low
   input  wire logic                     cke_i,      // clock enable pin
   input  wire logic                     cs_i,       // chip select pin
   input  wire logic [5:0]               ca_i,       // command-address
   input  wire logic                     bl_otf_i,   // on-the-fly burst on
   input  wire logic                     clk_chg_i,  // clock change done
   output cmd_decode_pkg::cmd_word_t     cmd_o,      // decoded command
   output logic                          cmd_vld_o,  // one-cycle pulse
   output logic                          ready_o     // normal operation
);
   typedef enum logic [0:0] {
      ST_FIRST  = 1'b0,
      ST_SECOND = 1'b1
   } phase_t;

   phase_t                     phase_q;
   logic [5:0]                 first_q;
   cmd_decode_pkg::cmd_t       dec;
   logic [3:0]                 rdy_cnt_q;
   logic                       active;

   // a stopped or cke-low clock is not looked at
   // clock ignored while stopped
   assign active = cke_i && ready_o;

   // first-edge opcode lookup
   // cas-2 code
   always_comb begin
      dec = cmd_decode_pkg::CMD_RFU;
      if (first_q[cmd_decode_pkg::CA_ACT]) begin
         dec = first_q[cmd_decode_pkg::CA_AC2] ? cmd_decode_pkg::CMD_ACT2
                                               : cmd_decode_pkg::CMD_ACT1;
      end else begin
         unique case (first_q[4:0])
            cmd_decode_pkg::OP_MPC:  dec = cmd_decode_pkg::CMD_MPC;
            cmd_decode_pkg::OP_PRE:  dec = cmd_decode_pkg::CMD_PRE;
            cmd_decode_pkg::OP_REF:  dec = cmd_decode_pkg::CMD_REF;
            cmd_decode_pkg::OP_SRE:  dec = cmd_decode_pkg::CMD_SRE;
            cmd_decode_pkg::OP_WR1:  dec = cmd_decode_pkg::CMD_WR1;
            cmd_decode_pkg::OP_SRX:  dec = cmd_decode_pkg::CMD_SRX;
            cmd_decode_pkg::OP_RD1:  dec = cmd_decode_pkg::CMD_RD1;
            cmd_decode_pkg::OP_CAS2: dec = cmd_decode_pkg::CMD_CAS2;
            cmd_decode_pkg::OP_MRW1: dec = cmd_decode_pkg::CMD_MRW1;
            cmd_decode_pkg::OP_MRW2: dec = cmd_decode_pkg::CMD_MRW2;
            cmd_decode_pkg::OP_MRR1: dec = cmd_decode_pkg::CMD_MRR1;
            cmd_decode_pkg::OP_MWR1: begin
               // masked write needs ca5 low on the first edge
               dec = first_q[cmd_decode_pkg::CA_AB] ? cmd_decode_pkg::CMD_RFU
                                                    : cmd_decode_pkg::CMD_MWR1;
            end
            default: dec = cmd_decode_pkg::CMD_RFU;
         endcase
      end
   end

   // two-edge framing: cs high opens, next edge closes
   // deselect handling
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         phase_q <= ST_FIRST;
         first_q <= 6'h00;
      end else if (!active) begin
         phase_q <= ST_FIRST;
      end else if (phase_q == ST_SECOND) begin
         phase_q <= ST_FIRST;
      end else if (cs_i) begin
         phase_q <= ST_SECOND;
         first_q <= ca_i;
      end
   end

   // decoded command word, registered at the second edge
   // all-bank flag
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cmd_o     <= '0;
         cmd_vld_o <= 1'b0;
      end else begin
         cmd_vld_o <= 1'b0;
         if (active && phase_q == ST_SECOND) begin
            cmd_vld_o       <= (dec != cmd_decode_pkg::CMD_RFU);
            cmd_o.cmd       <= (dec == cmd_decode_pkg::CMD_RFU)
                               ? cmd_decode_pkg::CMD_NONE : dec;
            cmd_o.hi_bit    <= first_q[cmd_decode_pkg::CA_AB];
            cmd_o.first     <= first_q;
            cmd_o.second    <= ca_i;
            cmd_o.all_bank  <= first_q[cmd_decode_pkg::CA_AB] &&
                               (dec == cmd_decode_pkg::CMD_PRE ||
                                dec == cmd_decode_pkg::CMD_REF);
            cmd_o.bank      <= (first_q[cmd_decode_pkg::CA_AB] &&
                                (dec == cmd_decode_pkg::CMD_PRE ||
                                 dec == cmd_decode_pkg::CMD_REF))
                               ? 3'h0 : ca_i[2:0];
            cmd_o.burst     <= (bl_otf_i && first_q[cmd_decode_pkg::CA_AB] &&
                                (dec == cmd_decode_pkg::CMD_WR1 ||
                                 dec == cmd_decode_pkg::CMD_RD1))
                               ? cmd_decode_pkg::BL_LONG
                               : cmd_decode_pkg::BL_SHORT;
         end
      end
   end

   // ready delay after a cke-high clock change, loaded by clk_chg_i; none after reset
   // 2 tck plus txp wait
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rdy_cnt_q <= 4'h0;
      end else if (clk_chg_i) begin
         rdy_cnt_q <= cmd_decode_pkg::READY_CNT;
      end else if (rdy_cnt_q != 4'h0) begin
         rdy_cnt_q <= rdy_cnt_q - 4'h1;
      end
   end
   assign ready_o = (rdy_cnt_q == 4'h0) && !clk_chg_i;

   // ready held low for the full wait
   sequence chg_s;
      clk_chg_i ##1 !clk_chg_i;
   endsequence
   ready_wait_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      chg_s |-> !ready_o [*7] ##1 ready_o)
      else $error("ready timing after clock change wrong");

   // a valid command follows a cs-high edge by two edges
   two_edge_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o |-> $past(cs_i, 2) && $past(active, 2))
      else $error("command without a first edge");

   all_bank_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o && cmd_o.all_bank |-> cmd_o.bank == 3'h0)
      else $error("all-bank command kept bank address");

   // long burst only with otf and bit high
   burst_sel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o && cmd_o.cmd inside {cmd_decode_pkg::CMD_WR1,
                                     cmd_decode_pkg::CMD_RD1} |->
         (cmd_o.burst == cmd_decode_pkg::BL_LONG) ==
         ($past(bl_otf_i) && cmd_o.hi_bit))
      else $error("burst length select wrong");

   idle_clk_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !active |=> !cmd_vld_o)
      else $error("command decoded while clock ignored");

   // cas-2 column bits come from second edge
   cas_col_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o && cmd_o.cmd == cmd_decode_pkg::CMD_CAS2 |->
         cmd_o.second == $past(ca_i) &&
         cmd_o.first[4:0] == cmd_decode_pkg::OP_CAS2)
      else $error("cas-2 fields wrong");

   // bank taken from second edge for per-bank precharge
   pre_bank_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o && cmd_o.cmd == cmd_decode_pkg::CMD_PRE && !cmd_o.hi_bit
         |-> cmd_o.bank == $past(ca_i[2:0]))
      else $error("precharge bank wrong");

   // cs low in first phase yields no command two edges on
   deselect_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      phase_q == ST_FIRST && !cs_i |-> ##2 !cmd_vld_o)
      else $error("deselect produced a command");

   rfu_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o |-> cmd_o.cmd != cmd_decode_pkg::CMD_NONE)
      else $error("reserved code reported");

   // mode write-2 keeps its first-edge code
   mrw_code_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o && cmd_o.cmd == cmd_decode_pkg::CMD_MRW2 |->
         cmd_o.first[4:0] == cmd_decode_pkg::OP_MRW2)
      else $error("mode write-2 code wrong");

   // a framed command always updates the output word
   sequence frame_s;
      active && phase_q == ST_FIRST && cs_i ##1 active;
   endsequence
   frame_ok_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      frame_s |=> cmd_vld_o == (cmd_o.cmd != cmd_decode_pkg::CMD_NONE))
      else $error("framed command not reported");

   // cke low closes an open frame
   cke_drop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !cke_i |=> phase_q == ST_FIRST)
      else $error("frame kept open with cke low");

   // activate halves split on ca1 of the first edge
   act_half_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_vld_o && cmd_o.first[cmd_decode_pkg::CA_ACT] |->
         cmd_o.cmd inside {cmd_decode_pkg::CMD_ACT1, cmd_decode_pkg::CMD_ACT2}
         && cmd_o.first[cmd_decode_pkg::CA_AC2] ==
            (cmd_o.cmd == cmd_decode_pkg::CMD_ACT2))
      else $error("activate half decoded wrong");
endmodule

// ===== test/ctrl_model.sv
// controller model driving clock enable, chip select and command lines
`timescale 1ns/1ns
module ctrl_model (
   input  wire logic       clk_i, // command clock
   output logic            cke_o, // clock enable
   output logic            cs_o,  // chip select
   output logic [5:0]      ca_o   // command-address
);
   // clock enable starts high, until set_cke changes it
   initial begin
      cke_o = 1'b1;
      cs_o  = 1'b0;
      ca_o  = 6'h2A;
   end
   // two-edge frame, first half opens with cs high
   task automatic send(input logic [5:0] f, input logic [5:0] s);
      @(posedge clk_i) #1;
      cs_o = 1'b1;
      ca_o = f;
      @(posedge clk_i) #1;
      cs_o = 1'b0;
      ca_o = s;
   endtask
   task automatic idle();
      @(posedge clk_i) #1;
      cs_o = 1'b0;
      ca_o = ~ca_o;
   endtask
   task automatic set_cke(input logic v);
      cke_o = v;
   endtask
endmodule

// ===== test/cmd_decode_test.sv
// self-checking bench for the command decoder
`timescale 1ns/1ns
module cmd_decode_test;
   logic clk_i = 1'b0, rstn_i = 1'b0, bl_otf_i = 1'b0, clk_chg_i = 1'b0;
   logic                      cke, cs, cmd_vld_o, ready_o;
   logic [5:0]                ca;
   cmd_decode_pkg::cmd_word_t cmd_o, e, m;
   cmd_decode_pkg::cmd_word_t notes[$];
   int error_cnt = 0, comparisons = 0, seed = 54161, n;
   always #2 clk_i = ~clk_i;
   ctrl_model i_ctrl_model (.clk_i(clk_i), .cke_o(cke), .cs_o(cs), .ca_o(ca));
   cmd_decode i_cmd_decode (.clk_i(clk_i), .rstn_i(rstn_i), .cke_i(cke),
      .cs_i(cs), .ca_i(ca), .bl_otf_i(bl_otf_i), .clk_chg_i(clk_chg_i),
      .cmd_o(cmd_o), .cmd_vld_o(cmd_vld_o), .ready_o(ready_o));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // expected decode of the first edge
   function automatic cmd_decode_pkg::cmd_t dec(input logic [5:0] f);
      if (f[0])
         return f[1] ? cmd_decode_pkg::CMD_ACT2 : cmd_decode_pkg::CMD_ACT1;
      case (f[4:0])
         5'h00: return cmd_decode_pkg::CMD_MPC;
         5'h10: return cmd_decode_pkg::CMD_PRE;
         5'h08: return cmd_decode_pkg::CMD_REF;
         5'h18: return cmd_decode_pkg::CMD_SRE;
         5'h04: return cmd_decode_pkg::CMD_WR1;
         5'h14: return cmd_decode_pkg::CMD_SRX;
         5'h0C: return f[5] ? cmd_decode_pkg::CMD_NONE
                            : cmd_decode_pkg::CMD_MWR1;
         5'h02: return cmd_decode_pkg::CMD_RD1;
         5'h12: return cmd_decode_pkg::CMD_CAS2;
         5'h06: return cmd_decode_pkg::CMD_MRW1;
         5'h16: return cmd_decode_pkg::CMD_MRW2;
         5'h0E: return cmd_decode_pkg::CMD_MRR1;
         default: return cmd_decode_pkg::CMD_NONE;
      endcase
   endfunction
   // note the expected word, then hand the frame to the controller
   task automatic cmd(input logic [5:0] f, input logic [5:0] s, input bit ok);
      e = '0;
      e.cmd = dec(f);
      e.hi_bit = f[5];
      e.first = f;
      e.second = s;
      e.all_bank = f[5] && (e.cmd inside {cmd_decode_pkg::CMD_PRE,
                                          cmd_decode_pkg::CMD_REF});
      e.bank = s[2:0];
      e.burst = (bl_otf_i && f[5] && (e.cmd inside {cmd_decode_pkg::CMD_WR1,
                                                    cmd_decode_pkg::CMD_RD1}))
                ? cmd_decode_pkg::BL_LONG : cmd_decode_pkg::BL_SHORT;
      if (ok && e.cmd != cmd_decode_pkg::CMD_NONE) notes.push_back(e);
      i_ctrl_model.send(f, s);
   endtask
   // compare each decoded command against the oldest note
   always @(negedge clk_i) if (rstn_i && cmd_vld_o === 1'b1) begin
      if (notes.size() == 0) check(8'h01, 8'h00);
      else begin
         m = notes.pop_front();
         check(cmd_o.cmd, m.cmd);
         check(cmd_o.first, m.first);
         check(cmd_o.second, m.second);
         check(cmd_o.hi_bit, m.hi_bit);
         check(cmd_o.all_bank, m.all_bank);
         if (!m.all_bank) check(cmd_o.bank, m.bank);
         check(cmd_o.burst, m.burst);
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      check(ready_o, 8'h01);
      check(cmd_vld_o, 8'h00);
      // every first-edge code, with random idle gaps, both burst modes
      for (int j = 0; j < 2; j++) begin
         i_ctrl_model.idle();
         bl_otf_i = j[0];
         for (int i = 0; i < 64; i++) begin
            cmd(6'(i), 6'($random(seed)), 1'b1);
            if ($random(seed) & 1) i_ctrl_model.idle();
         end
      end
      // frame with clock enable low is ignored
      i_ctrl_model.idle();
      // clock runs on after cke falls
      i_ctrl_model.set_cke(1'b0);
      cmd(6'h10, 6'h05, 1'b0);
      i_ctrl_model.idle();
      i_ctrl_model.set_cke(1'b1);
      rstn_i = 1'b0;
      @(posedge clk_i) #1;
      rstn_i = 1'b1;
      check(ready_o, 8'h01);
      check(cmd_vld_o, 8'h00);
      check(cmd_o.cmd, cmd_decode_pkg::CMD_NONE);
      repeat (4) i_ctrl_model.idle();
      clk_chg_i = 1'b1;
      @(posedge clk_i) #1;
      clk_chg_i = 1'b0;
      check(ready_o, 8'h00);
      cmd(6'h08, 6'h03, 1'b0);
      n = 2; // low cycles seen before the loop starts
      while (ready_o !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_i) #1;
      end
      check(8'(n), 8'(cmd_decode_pkg::READY_CYC));
      cmd(6'h28, 6'h02, 1'b1);
      cmd(6'h06, 6'h0D, 1'b1);
      cmd(6'h16, 6'h21, 1'b1);
      cmd(6'h22, 6'h05, 1'b1);
      cmd(6'h12, 6'h3F, 1'b1);
      repeat (3) i_ctrl_model.idle();
      check(8'(notes.size()), 8'h00);
      results();
   end
endmodule
